// >>> ifep_ctrl.v
// Interrupt flag, enable and priority block with APB register access
//
// Contract
// - Flag bits 15..8: uart2 tx, uart2 rx, ext2, timer5, timer4, oc4, oc3, dma2.
// - Flag bits 7,6: capture8/7; bits 4..0: ext1, cn, cmp, i2c master/slave.
// - Flags set on source request, software read/write, reset to zero.
// - Enable register mirrors flag layout, read/write, reset to zero.
// - Enable bit one passes the request on; zero blocks it.
// - Four 3-bit priority fields: timer4, compare4, compare3, dma2 done.
// - Priority 7 highest down to 1; code 0 disables the source.
// - Priority fields reset to level 4.
// - Unimplemented bits ignore writes and read zero.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ifep_map.vh"

module ifep_ctrl #(
  parameter NSRC = `IFEP_NSRC,
  parameter PW = `IFEP_PRIO_W
) (
  // Clock and reset
  input wire core_clk,
  input wire arst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Peripheral request levels, one per flag position, high for at least two cycles
  input wire [NSRC-1:0] src_req,
  // Request to the core
  output reg irq_valid,
  output reg [3:0] irq_src_id,
  output reg [PW-1:0] irq_level,
  // Block interrupt
  output wire blk_irq
);

  // ---------------------------------------------------------------
  // Priority lookup per source
  // ---------------------------------------------------------------
  function [PW-1:0] src_prio;
    input [15:0] prios;
    input [3:0] idx;
    begin
      // Sources without a priority field here run at default level
      case (idx)
        `IFEP_BIT_T4: src_prio = prios[`IFEP_PRIO_LSB_T4 +: PW];
        `IFEP_BIT_OC4: src_prio = prios[`IFEP_PRIO_LSB_OC4 +: PW];
        `IFEP_BIT_OC3: src_prio = prios[`IFEP_PRIO_LSB_OC3 +: PW];
        `IFEP_BIT_DMA2: src_prio = prios[`IFEP_PRIO_LSB_DMA2 +: PW];
        default: src_prio = `IFEP_PRIO_DEFAULT;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [15:0] flags_q;
  reg [15:0] enables_q;
  reg [15:0] prios_q;
  reg [1:0] status_q;
  reg [1:0] mask_q;

  // Three-stage input synchroniser and edge detect
  reg [NSRC-1:0] req_s1_q;
  reg [NSRC-1:0] req_s2_q;
  reg [NSRC-1:0] req_s3_q;
  reg [NSRC-1:0] req_lvl_q;
  wire [NSRC-1:0] req_rise;
  wire [15:0] hw_set;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_q <= {NSRC{1'b0}};
      req_s2_q <= {NSRC{1'b0}};
      req_s3_q <= {NSRC{1'b0}};
      req_lvl_q <= {NSRC{1'b0}};
    end else begin
      req_s1_q <= src_req;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      // Level follows once stages two and three agree
      req_lvl_q <= (req_s2_q & req_s3_q) |
        (req_lvl_q & (req_s2_q | req_s3_q));
    end
  end

  assign req_rise = req_s2_q & req_s3_q & ~req_lvl_q;
  assign hw_set = req_rise[15:0] & `IFEP_SRC_MASK;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire acc;
  wire wr;
  wire hit;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  assign hit = (paddr == `IFEP_ADDR_FLAGS) | (paddr == `IFEP_ADDR_ENABLES) |
               (paddr == `IFEP_ADDR_PRIOS) | (paddr == `IFEP_ADDR_ACTIVE) |
               (paddr == `IFEP_ADDR_STATUS) | (paddr == `IFEP_ADDR_MASK);
  assign pslverr = acc & ~hit;

  wire wr_flags;
  wire wr_en;
  wire wr_prio;
  wire wr_stat;
  wire wr_mask;
  assign wr_flags = wr & (paddr == `IFEP_ADDR_FLAGS);
  assign wr_en = wr & (paddr == `IFEP_ADDR_ENABLES);
  assign wr_prio = wr & (paddr == `IFEP_ADDR_PRIOS);
  assign wr_stat = wr & (paddr == `IFEP_ADDR_STATUS);
  assign wr_mask = wr & (paddr == `IFEP_ADDR_MASK);

  // ---------------------------------------------------------------
  // Flag, enable and priority registers
  // ---------------------------------------------------------------
  reg [15:0] flags_d;
  always @* begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = pwdata[15:0] & `IFEP_SRC_MASK;
    end
    flags_d = flags_d | hw_set;
  end

  // Event: a request arrived while its flag was already set and was not being written with a one
  wire drop_evt;
  assign drop_evt = |(hw_set & flags_q & ~(wr_flags ? pwdata[15:0] : 16'h0000));

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= `IFEP_FLAGS_RESET;
      enables_q <= `IFEP_FLAGS_RESET;
      prios_q <= `IFEP_PRIO_RESET;
      mask_q <= `IFEP_EVT_RESET;
      status_q <= `IFEP_EVT_RESET;
    end else begin
      flags_q <= flags_d;
      if (wr_en) begin
        enables_q <= pwdata[15:0] & `IFEP_SRC_MASK;
      end
      if (wr_prio) begin
        prios_q <= pwdata[15:0] & `IFEP_PRIO_MASK;
      end
      if (wr_mask) begin
        mask_q <= pwdata[1:0];
      end
      // Set wins over write-one-to-clear
      status_q[`IFEP_EVT_NEW] <= (|hw_set) |
        (status_q[`IFEP_EVT_NEW] & ~(wr_stat & pwdata[`IFEP_EVT_NEW]));
      status_q[`IFEP_EVT_DROP] <= drop_evt |
        (status_q[`IFEP_EVT_DROP] & ~(wr_stat & pwdata[`IFEP_EVT_DROP]));
    end
  end

  assign blk_irq = |(status_q & mask_q);

  // ---------------------------------------------------------------
  // Arbitration: highest priority pending, lowest index on tie
  // ---------------------------------------------------------------
  wire [15:0] pending;
  assign pending = flags_q & enables_q;

  reg best_v;
  reg [3:0] best_id;
  reg [PW-1:0] best_p;
  reg [PW-1:0] cur_p;
  integer i;
  always @* begin
    best_v = 1'b0;
    best_id = 4'h0;
    best_p = `IFEP_PRIO_OFF;
    cur_p = `IFEP_PRIO_OFF;
    for (i = 0; i < NSRC; i = i + 1) begin
      cur_p = src_prio(prios_q, i[3:0]);
      // Code zero never wins, so disabled sources drop out
      if (pending[i] && cur_p > best_p) begin
        best_v = 1'b1;
        best_id = i[3:0];
        best_p = cur_p;
      end
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_valid <= 1'b0;
      irq_src_id <= 4'h0;
      irq_level <= `IFEP_PRIO_OFF;
    end else begin
      irq_valid <= best_v;
      irq_src_id <= best_id;
      irq_level <= best_p;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `IFEP_ADDR_FLAGS: prdata <= {16'h0000, flags_q};
        `IFEP_ADDR_ENABLES: prdata <= {16'h0000, enables_q};
        `IFEP_ADDR_PRIOS: prdata <= {16'h0000, prios_q};
        `IFEP_ADDR_ACTIVE: prdata <= {24'h000000, best_v, best_p, best_id};
        `IFEP_ADDR_STATUS: prdata <= {30'h00000000, status_q};
        `IFEP_ADDR_MASK: prdata <= {30'h00000000, mask_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // ifep_ctrl
`default_nettype wire

// >>> ifep_map.vh
// Register map and constants for the interrupt flag/enable/priority block
`ifndef IFEP_MAP_VH
`define IFEP_MAP_VH
// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define IFEP_ADDR_FLAGS 12'h000
`define IFEP_ADDR_ENABLES 12'h004
`define IFEP_ADDR_PRIOS 12'h008
`define IFEP_ADDR_ACTIVE 12'h00c
`define IFEP_ADDR_STATUS 12'h010
`define IFEP_ADDR_MASK 12'h014
// ---------------------------------------------------------------
// Field layouts and reset values
// ---------------------------------------------------------------
`define IFEP_SRC_MASK 16'hffdf
`define IFEP_PRIO_MASK 16'h7777
`define IFEP_PRIO_RESET 16'h4444
`define IFEP_FLAGS_RESET 16'h0000
`define IFEP_EVT_RESET 2'h0
`define IFEP_NSRC 16
`define IFEP_PRIO_W 3
`define IFEP_PRIO_LSB_T4 12
`define IFEP_PRIO_LSB_OC4 8
`define IFEP_PRIO_LSB_OC3 4
`define IFEP_PRIO_LSB_DMA2 0
`define IFEP_BIT_T4 11
`define IFEP_BIT_OC4 10
`define IFEP_BIT_OC3 9
`define IFEP_BIT_DMA2 8
`define IFEP_PRIO_DEFAULT 3'h4
`define IFEP_PRIO_OFF 3'h0
`define IFEP_EVT_NEW 0
`define IFEP_EVT_DROP 1
`endif

// >>> ifep_checker.sv
// Assertion checker for the interrupt flag, enable and priority block
`timescale 1ns/1ps
`default_nettype none
`include "ifep_map.vh"
module ifep_checker #(parameter NSRC = 16, parameter PW = 3) (
  // Clock, reset and APB
  input wire logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Requests and outputs
  input wire logic [NSRC-1:0] src_req,
  input wire logic irq_valid, blk_irq,
  input wire logic [3:0] irq_src_id,
  input wire logic [PW-1:0] irq_level
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire rd = psel && penable && !pwrite;
  wire wr = psel && penable && pwrite;
  logic en_wr_q, pr_wr_q;
  // Remembers whether a register has been written since reset
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_wr_q <= 1'b0;
      pr_wr_q <= 1'b0;
    end else begin
      en_wr_q <= en_wr_q | (wr && paddr == `IFEP_ADDR_ENABLES);
      pr_wr_q <= pr_wr_q | (wr && paddr == `IFEP_ADDR_PRIOS);
    end
  end
  sequence quiet;
    (!wr && $stable(src_req)) [*6];
  endsequence
  AST_READY: assert property (pready)
    else $error("pready low");
  AST_SRC_MASK: assert property (rd && (paddr == `IFEP_ADDR_FLAGS ||
    paddr == `IFEP_ADDR_ENABLES) |-> (prdata & ~32'h0000ffdf) == 32'h0)
    else $error("flag or enable read has unused bits set");
  AST_PRIO_MASK: assert property (rd && paddr == `IFEP_ADDR_PRIOS |->
    (prdata & ~32'h00007777) == 32'h0) else $error("priority read bad bits");
  AST_PRIO_RESET: assert property (rd && paddr == `IFEP_ADDR_PRIOS &&
    !pr_wr_q |-> prdata == 32'h00004444) else $error("priority reset value");
  AST_EN_RESET: assert property (rd && paddr == `IFEP_ADDR_ENABLES &&
    !en_wr_q |-> prdata == 32'h0) else $error("enable reset value");
  AST_UNMAPPED: assert property (psel && penable && paddr > 12'h014 |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access");
  AST_LEVEL_NZ: assert property (irq_valid |-> irq_level != 3'h0)
    else $error("request forwarded at level zero");
  AST_QUIET: assert property (quiet |->
    $stable({irq_valid, irq_src_id, irq_level, blk_irq}))
    else $error("request outputs moved without cause");
endmodule // ifep_checker
bind ifep_ctrl ifep_checker #(.NSRC(NSRC), .PW(PW)) i_ifep_checker (
  .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .src_req(src_req), .blk_irq(blk_irq),
  .irq_valid(irq_valid), .irq_src_id(irq_src_id), .irq_level(irq_level));
`default_nettype wire

// >>> ifep_src_model.sv
// Peripheral request source model
`timescale 1ns/1ps
`default_nettype none
module ifep_src_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic fire,
  input wire logic [15:0] fire_mask,
  output logic [15:0] src_req
);
  // Request levels follow fire, low otherwise
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) src_req <= 16'h0000;
    else src_req <= fire ? fire_mask : 16'h0000;
  end
endmodule // ifep_src_model
`default_nettype wire

// >>> tb_interrupt_flag_enable_priority.sv
// Testbench for the interrupt flag, enable and priority block
`timescale 1ns/1ps
`default_nettype none
`include "ifep_map.vh"
module tb_interrupt_flag_enable_priority;
  logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, fire = 1'b0, pready, pslverr, irq_valid, blk_irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] fire_mask = 16'h0, src_req;
  logic [3:0] irq_src_id;
  logic [2:0] irq_level;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  ifep_ctrl i_ifep_ctrl (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .src_req(src_req),
    .irq_valid(irq_valid), .irq_src_id(irq_src_id), .irq_level(irq_level),
    .blk_irq(blk_irq));
  ifep_src_model i_ifep_src_model (.core_clk(core_clk), .arst_n(arst_n),
    .fire(fire), .fire_mask(fire_mask), .src_req(src_req));
  initial forever #5 core_clk = ~core_clk;
  task wrap_up;
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up;
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task chk(input logic [31:0] e);
    samples_checked++;
    if (rd !== e) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, rd, e);
    end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rdc(`IFEP_ADDR_FLAGS, 32'h0);
    rdc(`IFEP_ADDR_ENABLES, 32'h0);
    rdc(`IFEP_ADDR_PRIOS, 32'h4444);
    rdc(12'h018, 32'h0);
    apb(1'b1, `IFEP_ADDR_PRIOS, 32'hffffffff);
    rdc(`IFEP_ADDR_PRIOS, 32'h7777);
    apb(1'b1, `IFEP_ADDR_FLAGS, 32'hffff);
    rdc(`IFEP_ADDR_FLAGS, 32'hffdf);
    apb(1'b1, `IFEP_ADDR_FLAGS, 32'h0);
    apb(1'b1, `IFEP_ADDR_ENABLES, 32'hffff);
    rdc(`IFEP_ADDR_ENABLES, 32'hffdf);
    apb(1'b1, `IFEP_ADDR_PRIOS, 32'h7111);
    apb(1'b1, `IFEP_ADDR_STATUS, 32'h3);
    apb(1'b1, `IFEP_ADDR_MASK, 32'h1);
    fire <= 1'b1; fire_mask <= 16'h8820;
    repeat (4) @(posedge core_clk);
    fire <= 1'b0;
    repeat (8) @(posedge core_clk);
    rdc(`IFEP_ADDR_FLAGS, 32'h8800);
    rdc(`IFEP_ADDR_ACTIVE, 32'hfb);
    rdc(`IFEP_ADDR_STATUS, 32'h1);
    rd = {31'h0, blk_irq};
    chk(32'h1);
    apb(1'b1, `IFEP_ADDR_PRIOS, 32'h0111);
    rdc(`IFEP_ADDR_ACTIVE, 32'hcf);
    apb(1'b1, `IFEP_ADDR_ENABLES, 32'h7fdf);
    apb(1'b0, `IFEP_ADDR_ACTIVE, 32'h0);
    rd = rd & 32'h80;
    chk(32'h0);
    apb(1'b1, `IFEP_ADDR_MASK, 32'h0);
    rd = {31'h0, blk_irq};
    chk(32'h0);
    apb(1'b1, `IFEP_ADDR_STATUS, 32'h1);
    rdc(`IFEP_ADDR_STATUS, 32'h0);
    wrap_up;
  end
endmodule // tb_interrupt_flag_enable_priority
`default_nettype wire
